/* File: rtl/crf_defs.svh */
// constants for the receive bit-timing filter block
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH
`define CRF_CORE_HZ 40000000
`define CRF_FS_HZ 32768
`define CRF_FS_DIV (`CRF_CORE_HZ / `CRF_FS_HZ)
`define CRF_FS_NS 30518
`define CRF_LOW_HOLD_US 3630
`define CRF_LOW_HOLD_FS ((`CRF_LOW_HOLD_US * 1000) / `CRF_FS_NS)
`define CRF_MIN_BASE 8'h43
`define CRF_MIN_ADD_MAX 3'h3
`define CRF_OFF_RCR1 12'h000
`define CRF_OFF_STAT 12'h004
`define CRF_OFF_MASK 12'h008
`define CRF_OFF_ADDR 12'h00c
`define CRF_ACKDIS_BIT 24
`define CRF_HNC_HI 21
`define CRF_HNC_LO 20
`define CRF_LNC_HI 18
`define CRF_LNC_LO 16
`define CRF_MIN_HI 14
`define CRF_MIN_LO 12
`define CRF_RCR1_MASK 32'h0137_7000
`define CRF_ST_MINERR 0
`define CRF_ST_ACK 1
`define CRF_ST_W 2
`endif

/* File: rtl/crf_pkg.sv */
// types shared by the receive bit-timing filter block
package crf_pkg;
	typedef enum logic [1:0] {CRF_IDLE, CRF_SETUP, CRF_ACCESS} crf_apb_t;
	typedef logic [7:0] crf_fscnt_t;
endpackage

/* File: rtl/crf_top.sv */
// receive front end: line filter, minimum bit-cycle check, acknowledge drive, apb registers
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "crf_defs.svh"
module crf_top
	import crf_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic line_in,
	output logic line_out,
	output logic line_oe,
	input wire logic [3:0] rx_dest_addr,
	input wire logic hdr_ack_slot,
	input wire logic data_ack_slot,
	output logic line_filt,
	output logic irq
);
	logic [31:0] rcr1_r;
	logic [`CRF_ST_W-1:0] stat_r;
	logic [`CRF_ST_W-1:0] mask_r;
	logic [3:0] laddr_r;
	logic [10:0] div_r;
	logic fs_tick_r;
	logic [1:0] run_r;
	logic filt_r;
	logic filt_d_r;
	crf_fscnt_t cyc_r;
	logic cyc_valid_r;
	crf_fscnt_t hold_r;
	logic ack_drive_r;
	logic ack_prev_r;
	logic min_err_r;
	logic [1:0] need_hi;
	logic [1:0] need_lo;
	logic filt_nxt;
	logic [1:0] run_nxt;
	crf_fscnt_t min_cyc;
	logic [2:0] min_code;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic [31:0] rd_nxt;
	logic fall;
	logic addr_match;
	logic ack_nxt;
	logic clr_minerr;
	logic clr_ack;
	logic ack_end;
	logic hold_busy;

	// writes land on the edge at which the master sees pready, not one cycle early
	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && penable && !pwrite && !pready;
	assign fall = filt_d_r && !filt_r;
	assign addr_match = rx_dest_addr == laddr_r;
	assign min_code = rcr1_r[`CRF_MIN_HI:`CRF_MIN_LO];
	assign clr_minerr = wr_en && paddr == `CRF_OFF_STAT && pwdata[`CRF_ST_MINERR];
	assign clr_ack = wr_en && paddr == `CRF_OFF_STAT && pwdata[`CRF_ST_ACK];
	assign ack_end = ack_prev_r && !ack_drive_r;
	// let go of the wire on the tick that takes the hold counter to zero
	assign hold_busy = hold_r > 8'h01 || (hold_r == 8'h01 && !fs_tick_r);

	// reserved low-filter codes behave like the longest legal one
	always_comb
	begin
		need_hi = rcr1_r[`CRF_HNC_HI:`CRF_HNC_LO];
		if (rcr1_r[`CRF_LNC_HI])
			need_lo = 2'h3;
		else
			need_lo = rcr1_r[`CRF_LNC_HI-1:`CRF_LNC_LO];
	end

	always_comb
	begin
		if (min_code <= `CRF_MIN_ADD_MAX)
			min_cyc = `CRF_MIN_BASE + {5'h00, min_code};
		else
			// codes above the add range take away (code - 3) periods
			min_cyc = `CRF_MIN_BASE - {5'h00, min_code} + {5'h00, `CRF_MIN_ADD_MAX};
	end

	// run counts samples disagreeing with the filtered level; accept when it reaches the need
	always_comb
	begin
		filt_nxt = filt_r;
		run_nxt = 2'h0;
		if (line_in != filt_r)
		begin
			if (line_in && run_r >= need_hi)
				filt_nxt = 1'b1;
			else if (!line_in && run_r >= need_lo)
				filt_nxt = 1'b0;
			else
				run_nxt = run_r + 2'h1;
		end
	end

	// fs is cut from the core clock; the dropped fraction makes fs run a little fast
	always_ff @(posedge core_clk)
	begin
		if (rst || div_r == 11'(`CRF_FS_DIV - 1))
			div_r <= 11'h000;
		else
			div_r <= div_r + 11'h001;
		fs_tick_r <= !rst && div_r == 11'(`CRF_FS_DIV - 1);
	end

	// the filter also serves acks seen during our own transmission: no mode gate
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			filt_r <= 1'b1;
			filt_d_r <= 1'b1;
			run_r <= 2'h0;
		end
		else
		begin
			filt_d_r <= filt_r;
			if (fs_tick_r)
			begin
				filt_r <= filt_nxt;
				run_r <= run_nxt;
			end
		end
	end

	// counter saturates so a long idle never wraps into a false short cycle
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			cyc_r <= 8'h00;
			cyc_valid_r <= 1'b0;
			min_err_r <= 1'b0;
		end
		else
		begin
			// the first fall after reset has nothing to measure against and only opens the count
			min_err_r <= fall && cyc_valid_r && cyc_r < min_cyc && hold_r == 8'h00;
			if (fall)
			begin
				cyc_r <= 8'h00;
				cyc_valid_r <= 1'b1;
			end
			else if (fs_tick_r && cyc_r != 8'hff)
				cyc_r <= cyc_r + 8'h01;
		end
	end

	// our own low-hold produces falling edges; ignore them while holding
	always_ff @(posedge core_clk)
	begin
		if (rst)
			hold_r <= 8'h00;
		else if (min_err_r)
			// the low time is rounded down to whole fs periods
			hold_r <= 8'(`CRF_LOW_HOLD_FS);
		else if (fs_tick_r && hold_r != 8'h00)
			hold_r <= hold_r - 8'h01;
	end

	always_comb
	begin
		// header acks ignore the suppress bit; only data-block acks obey it
		ack_nxt = 1'b0;
		if (hdr_ack_slot && addr_match)
			ack_nxt = 1'b1;
		else if (data_ack_slot && addr_match && !rcr1_r[`CRF_ACKDIS_BIT])
			ack_nxt = 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ack_drive_r <= 1'b0;
			ack_prev_r <= 1'b0;
		end
		else
		begin
			ack_drive_r <= ack_nxt;
			ack_prev_r <= ack_drive_r;
		end
	end

	// open-drain pin: the data level is fixed low and line_oe alone pulls the wire
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			line_oe <= 1'b0;
			line_out <= 1'b0;
		end
		else
		begin
			line_oe <= ack_nxt || min_err_r || hold_busy;
			line_out <= 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			line_filt <= 1'b1;
		else
			line_filt <= filt_r;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			rcr1_r <= 32'h0000_0000;
		else if (wr_en && paddr == `CRF_OFF_RCR1)
			// reserved bits are dropped here so they always read back as zero
			rcr1_r <= pwdata & `CRF_RCR1_MASK;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			mask_r <= '0;
		else if (wr_en && paddr == `CRF_OFF_MASK)
			mask_r <= pwdata[`CRF_ST_W-1:0];
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			laddr_r <= 4'h0;
		else if (wr_en && paddr == `CRF_OFF_ADDR)
			laddr_r <= pwdata[3:0];
	end

	// a new event in the clearing cycle wins over the write-one clear
	always_ff @(posedge core_clk)
	begin
		if (rst)
			stat_r <= '0;
		else
		begin
			stat_r[`CRF_ST_MINERR] <= min_err_r || (stat_r[`CRF_ST_MINERR] && !clr_minerr);
			stat_r[`CRF_ST_ACK] <= ack_end || (stat_r[`CRF_ST_ACK] && !clr_ack);
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(stat_r & mask_r);
	end

	always_comb
	begin
		addr_ok = 1'b1;
		rd_nxt = 32'h0000_0000;
		unique case (paddr)
			`CRF_OFF_RCR1: rd_nxt = rcr1_r;
			`CRF_OFF_STAT: rd_nxt = {{(32-`CRF_ST_W){1'b0}}, stat_r};
			`CRF_OFF_MASK: rd_nxt = {{(32-`CRF_ST_W){1'b0}}, mask_r};
			// bit 8 lets software poll the filtered line
			`CRF_OFF_ADDR: rd_nxt = {23'h000000, filt_r, 4'h0, laddr_r};
			default: addr_ok = 1'b0;
		endcase
	end

	// one wait state: pready is a flop so every output stays registered
	// read data is fetched in the first access cycle so it stands while pready does
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !addr_ok;
			if (rd_en)
				prdata <= addr_ok ? rd_nxt : 32'h0000_0000;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/crf_top_chk.sv */
// port assertions for the receive filter block
`timescale 1ns/1ps
`default_nettype none
module crf_top_chk(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic line_in,
	input wire logic line_oe,
	input wire logic line_filt,
	input wire logic irq,
	input wire logic hdr_ack_slot,
	input wire logic data_ack_slot
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_wait; psel && penable && !pready |=> pready; endproperty
	a_wait: assert property (p_wait) else $error("no answer after wait state");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_idle; !(psel && penable) |=> !pready; endproperty
	a_idle: assert property (p_idle) else $error("ready without access");
	property p_rst; disable iff (1'b0) rst |=> !line_oe && !irq && !pready; endproperty
	a_rst: assert property (p_rst) else $error("outputs active after reset");
	// the filter decides on the sample taken two edges before line_filt moves
	property p_fall; $fell(line_filt) |-> !$past(line_in, 2); endproperty
	a_fall: assert property (p_fall) else $error("filtered low without low input");
	property p_rise; $rose(line_filt) |-> $past(line_in, 2); endproperty
	a_rise: assert property (p_rise) else $error("filtered high without high input");
	property p_oe; $rose(line_oe) |-> $past(hdr_ack_slot || data_ack_slot || !line_filt); endproperty
	a_oe: assert property (p_oe) else $error("line pulled without cause");
endmodule
`default_nettype wire

/* File: testbench/crf_line_model.sv */
// other bus devices: open-drain line with pull-up
`timescale 1ns/1ps
`default_nettype none
module crf_line_model(
	input wire logic line_oe,
	input wire logic line_out,
	input wire logic far_low,
	output logic line_in
);
	// wired-and: the line only rises when nobody pulls it
	assign line_in = !((line_oe && !line_out) || far_low);
endmodule
`default_nettype wire

/* File: testbench/tb_crf_top.sv */
// self-checking bench for the receive filter block
`timescale 1ns/1ps
`default_nettype none
module tb_crf_top;
	logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, far_low = 0;
	logic hdr_ack_slot = 0, data_ack_slot = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic [3:0] rx_dest_addr = 4'h5;
	logic pready, pslverr, line_in, line_out, line_oe, line_filt, irq;
	int bad_count = 0, n_compared = 0;
	always #12.5 core_clk = ~core_clk;
	crf_top dut(.*);
	crf_line_model far(.line_oe(line_oe), .line_out(line_out), .far_low(far_low), .line_in(line_in));
	task summarize;
		if (bad_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp, input logic err);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		cyc(1);
		penable <= 1'b1;
		i = 0;
		do
		begin
			cyc(1);
			i++;
		end
		while (pready !== 1'b1 && i < 20);
		if (i >= 20)
		begin
			bad_count++;
			summarize;
		end
		chk(pslverr, err);
		if (!w)
			chk(prdata, exp);
		psel <= 1'b0;
		penable <= 1'b0;
		cyc(1);
	endtask
	task t_regs;
		chk(line_filt, 1);
		apb(0, 12'h000, 0, 32'h0000_0000, 0);
		apb(1, 12'h000, 32'hffff_ffff, 0, 0);
		apb(0, 12'h000, 0, 32'h0137_7000, 0);
		apb(0, 12'h010, 0, 32'h0000_0000, 1);
	endtask
	task t_ack;
		apb(1, 12'h000, 32'h0101_0000, 0, 0);
		apb(1, 12'h00c, 32'h0000_0005, 0, 0);
		apb(1, 12'h008, 32'h0000_0002, 0, 0);
		// a frame for another address gets no acknowledge
		rx_dest_addr <= 4'h3;
		hdr_ack_slot <= 1'b1;
		cyc(3);
		chk(line_oe, 0);
		rx_dest_addr <= 4'h5;
		cyc(3);
		chk(line_oe, 1);
		chk(line_out, 0);
		hdr_ack_slot <= 1'b0;
		data_ack_slot <= 1'b1;
		cyc(3);
		chk(line_oe, 0);
		apb(1, 12'h000, 32'h0001_0000, 0, 0);
		cyc(2);
		chk(line_oe, 1);
		data_ack_slot <= 1'b0;
		cyc(4);
		chk(irq, 1);
		apb(0, 12'h004, 0, 32'h0000_0002, 0);
		apb(1, 12'h004, 32'h0000_0002, 0, 0);
		cyc(2);
		chk(irq, 0);
	endtask
	task t_min;
		// a single low sample is noise under the two-sample setting
		far_low <= 1'b1;
		cyc(1220);
		far_low <= 1'b0;
		cyc(3660);
		chk(line_filt, 1);
		far_low <= 1'b1;
		cyc(3660);
		chk(line_filt, 0);
		far_low <= 1'b0;
		cyc(6100);
		chk(line_filt, 1);
		far_low <= 1'b1;
		cyc(3660);
		far_low <= 1'b0;
		chk(line_oe, 1);
		apb(0, 12'h004, 0, 32'h0000_0001, 0);
		chk(irq, 0);
		apb(1, 12'h008, 32'h0000_0001, 0, 0);
		cyc(2);
		chk(irq, 1);
		apb(1, 12'h004, 32'h0000_0001, 0, 0);
		cyc(2);
		chk(irq, 0);
	endtask
	initial
	begin
		cyc(10);
		rst <= 1'b0;
		cyc(1);
		t_regs;
		t_ack;
		t_min;
		summarize;
	end
endmodule
bind crf_top crf_top_chk chk_i(.*);
`default_nettype wire
